// ===== hdl/sdl_pkg.sv
// Purpose: shared constants and carriers for the standalone logging sequencer
// Assumes: 100 MHz clk_sys
// Notes:   field positions follow the control word layout
package sdl_pkg;
	localparam int CLK_MHZ         = 100;
	localparam int WAKE_SS_US      = 1500;
	localparam int WAKE_SS_CYC     = WAKE_SS_US * CLK_MHZ;
	localparam int BOOT_WORDS      = 64;
	localparam int CTL_TIME        = 15;
	localparam int CTL_S2          = 14;
	localparam int CTL_S1          = 13;
	localparam int CTL_S0          = 12;
	localparam int CTL_LOOP        = 3;
	localparam int CTL_IRQ_RDY     = 2;
	localparam int CTL_HOLD        = 1;
	localparam int CTL_RUN         = 0;
	localparam logic [1:0] TAG_S0   = 2'h0;
	localparam logic [1:0] TAG_S1   = 2'h1;
	localparam logic [1:0] TAG_S2   = 2'h2;
	localparam logic [1:0] TAG_TIME = 2'h3;
	localparam logic [15:0] CTL_RESET = 16'h0000;
	localparam logic [2:0] COND_ALWAYS = 3'h0;
	localparam logic [2:0] COND_ABOVE  = 3'h1;
	localparam logic [2:0] COND_BELOW  = 3'h2;
	localparam logic [2:0] COND_OUTSIDE = 3'h3;

	typedef struct packed {
		logic [1:0]  tag;
		logic [13:0] code;
	} sdl_word_t;

	typedef struct packed {
		logic        valid;
		logic [15:0] addr;
		sdl_word_t   data;
	} sdl_ee_req_t;

	typedef enum logic [3:0] {
		SDL_BOOT, SDL_IDLE, SDL_SLEEP, SDL_PICK, SDL_CFG, SDL_ACQ,
		SDL_TEST, SDL_STORE, SDL_WAIT, SDL_DONE
	} sdl_state_t;
endpackage

// ===== hdl/sdl_fifo.sv
// Purpose: word fifo between result capture and the eeprom writer
// Assumes: single clock, synchronous active-low reset
// Notes:   depth must be a power of two
module sdl_fifo #(
	parameter int WIDTH = 16,
	parameter int DEPTH = 8
) (
	input  wire logic             clk_sys,
	input  wire logic             rst_b,
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic      [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW:0]      wr_ptr;
	logic [AW:0]      rd_ptr;
	logic             do_wr;
	logic             do_rd;

	assign in_ready  = (wr_ptr - rd_ptr) != (AW+1)'(DEPTH);
	assign out_valid = wr_ptr != rd_ptr;
	assign out_data  = mem[rd_ptr[AW-1:0]];
	assign do_wr     = in_valid && in_ready;
	assign do_rd     = out_valid && out_ready;

	always_ff @(posedge clk_sys) begin
		if (do_wr) begin
			mem[wr_ptr[AW-1:0]] <= in_data;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
		end else begin
			if (do_wr) begin
				wr_ptr <= wr_ptr + 1'b1;
			end
			if (do_rd) begin
				rd_ptr <= rd_ptr + 1'b1;
			end
		end
	end
endmodule

// ===== hdl/sdl_top.sv
// Purpose: standalone logging sequencer: boot copy, paced sensor logging
// Assumes: eeprom, sensor and boot copy ports are same-clock handshakes
// Notes:   ss_b and rf_field are pins and pass a two-stage synchroniser
module sdl_top #(
	parameter int WAKE_SS_CYCLES = sdl_pkg::WAKE_SS_CYC,
	parameter int DEPTH          = 8
) (
	input  wire logic        clk_sys,
	input  wire logic        rst_b,
	input  wire logic        boot_inhibit,
	input  wire logic        update_spi,
	input  wire logic        update_rfid,
	output logic             boot_req,
	input  wire logic        boot_done,
	input  wire logic [15:0] ctl_word,
	input  wire logic [15:0] dst_addr,
	input  wire logic [15:0] data_len,
	input  wire logic        log_arm,
	input  wire logic        sleep_mode_sel,
	input  wire logic [15:0] wake_period,
	input  wire logic        wake_irq_en,
	input  wire logic [7:0]  spi_cmd_write,
	input  wire logic [7:0]  spi_resp_delay,
	input  wire logic [2:0]  cond_s0,
	input  wire logic [2:0]  cond_s1,
	input  wire logic [2:0]  cond_s2,
	input  wire logic [13:0] thr_low,
	input  wire logic [13:0] thr_high,
	input  wire logic        ss_b,
	input  wire logic        rf_field,
	input  wire logic        spi_busy,
	input  wire logic        rfid_busy,
	output logic             sens_cfg_req,
	output logic [1:0]       sens_sel,
	input  wire logic        sens_cfg_done,
	output logic             acq_start,
	input  wire logic        acq_done,
	input  wire logic [13:0] acq_code,
	output logic             ee_wr_req,
	output logic [7:0]       ee_cmd,
	output sdl_pkg::sdl_ee_req_t ee_req,
	input  wire logic        ee_wr_ack,
	output logic [15:0]      words_copied,
	output logic             data_ready,
	output logic             full_flag,
	output logic             irq,
	output logic             sleeping,
	output logic             standby
);
	sdl_pkg::sdl_state_t state;
	logic [1:0]  ss_sync;
	logic [1:0]  rf_sync;
	logic [31:0] ss_low_cnt;
	logic [15:0] wake_cnt;
	logic [15:0] iter_idx;
	logic [15:0] wr_off;
	logic [7:0]  delay_cnt;
	logic [1:0]  cur;
	logic [3:0]  pending;
	logic        boot_pend;
	logic        boot_pwr;
	logic        wake_tick;
	logic        host_wake;
	logic        keep;
	logic [2:0]  cond;
	logic        f_in_valid;
	logic        f_in_ready;
	logic        f_out_valid;
	logic [15:0] f_out_data;
	logic        f_pop;
	sdl_pkg::sdl_word_t f_in_word;

	// pins are asynchronous; only stage 1 reads stage 0
	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			ss_sync <= 2'h3;
			rf_sync <= 2'h0;
		end else begin
			ss_sync <= {ss_sync[0], ss_b};
			rf_sync <= {rf_sync[0], rf_field};
		end
	end

	// wake on field or long slave-select low
	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			ss_low_cnt <= '0;
		end else if (ss_sync[1]) begin
			ss_low_cnt <= '0;
		end else if (ss_low_cnt < 32'(WAKE_SS_CYCLES)) begin
			ss_low_cnt <= ss_low_cnt + 32'h1;
		end
	end
	assign host_wake = rf_sync[1] || (ss_low_cnt >= 32'(WAKE_SS_CYCLES));

	// wake-up timer, counts only while sleeping
	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			wake_cnt <= '0;
		end else if (state != sdl_pkg::SDL_SLEEP) begin
			wake_cnt <= '0;
		end else if (wake_tick) begin
			wake_cnt <= '0;
		end else begin
			wake_cnt <= wake_cnt + 16'h1;
		end
	end
	assign wake_tick = (state == sdl_pkg::SDL_SLEEP) &&
		(wake_cnt + 16'h1 >= wake_period);

	always_comb begin
		cond = (cur == sdl_pkg::TAG_S0) ? cond_s0 :
			(cur == sdl_pkg::TAG_S1) ? cond_s1 : cond_s2;
		case (cond)
			sdl_pkg::COND_ABOVE:   keep = acq_code > thr_high;
			sdl_pkg::COND_BELOW:   keep = acq_code < thr_low;
			sdl_pkg::COND_OUTSIDE: keep = acq_code > thr_high ||
				acq_code < thr_low;
			default:               keep = 1'b1;
		endcase
	end

	always_comb begin
		f_in_valid = 1'b0;
		f_in_word  = '{tag: cur, code: acq_code};
		if (state == sdl_pkg::SDL_ACQ && acq_done && keep) begin
			f_in_valid = 1'b1;
		end else if (state == sdl_pkg::SDL_PICK && pending[3]) begin
			f_in_valid = 1'b1;
			f_in_word  = '{tag: sdl_pkg::TAG_TIME, code: iter_idx[13:0]};
		end
	end

	sdl_fifo #(.WIDTH(16), .DEPTH(DEPTH)) u_fifo (
		.clk_sys   (clk_sys),
		.rst_b     (rst_b),
		.in_valid  (f_in_valid),
		.in_ready  (f_in_ready),
		.in_data   (f_in_word),
		.out_valid (f_out_valid),
		.out_ready (f_pop),
		.out_data  (f_out_data)
	);

	// writer yields to host traffic; hold stops new words only
	assign f_pop = ee_wr_req && ee_wr_ack;

	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			ee_wr_req    <= 1'b0;
			ee_req       <= '0;
			ee_cmd       <= '0;
			delay_cnt    <= '0;
			wr_off       <= '0;
			words_copied <= '0;
			full_flag    <= 1'b0;
		end else if (!ctl_word[sdl_pkg::CTL_RUN] && state == sdl_pkg::SDL_IDLE
			&& !log_arm && !ee_wr_req) begin
			// stopped engine restarts from the start address
			wr_off    <= '0;
			full_flag <= 1'b0;
		end else if (ee_wr_req) begin
			if (ee_wr_ack) begin
				ee_wr_req    <= 1'b0;
				ee_req.valid <= 1'b0;
				// programmable gap before the next request
				delay_cnt    <= spi_resp_delay;
				words_copied <= words_copied + 16'h1;
				if (wr_off + 16'h1 >= data_len) begin
					full_flag <= 1'b1;
					if (ctl_word[sdl_pkg::CTL_LOOP]) begin
						wr_off <= '0;
					end else begin
						wr_off <= data_len;
					end
				end else begin
					wr_off <= wr_off + 16'h1;
				end
			end
		end else if (delay_cnt != 8'h0) begin
			delay_cnt <= delay_cnt - 8'h1;
		end else if (f_out_valid && !spi_busy && !rfid_busy &&
			!ctl_word[sdl_pkg::CTL_HOLD] &&
			(wr_off < data_len || ctl_word[sdl_pkg::CTL_LOOP])) begin
			ee_wr_req <= 1'b1;
			ee_cmd    <= spi_cmd_write;
			ee_req    <= '{valid: 1'b1, addr: dst_addr + wr_off,
				data: f_out_data};
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			iter_idx <= '0;
		end else if (wake_tick) begin
			iter_idx <= iter_idx + 16'h1;
		end
	end

	// boot copy request latch; an update wins over a finishing copy
	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			boot_pend <= 1'b1;
		end else if (update_spi || update_rfid) begin
			boot_pend <= 1'b1;
		end else if (state == sdl_pkg::SDL_BOOT && (boot_req ? boot_done :
			boot_pwr && boot_inhibit)) begin
			boot_pend <= 1'b0;
		end
	end

	// power-up copy is owed only until the first pass through boot
	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			boot_pwr <= 1'b1;
		end else if (state == sdl_pkg::SDL_BOOT) begin
			boot_pwr <= 1'b0;
		end
	end

	// main sequence; sensor enables are sampled at the wake tick only
	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			state        <= sdl_pkg::SDL_BOOT;
			cur          <= '0;
			pending      <= '0;
			boot_req     <= 1'b0;
			sens_cfg_req <= 1'b0;
			sens_sel     <= '0;
			acq_start    <= 1'b0;
			data_ready   <= 1'b0;
			irq          <= 1'b0;
			sleeping     <= 1'b0;
			standby      <= 1'b0;
		end else begin
			acq_start <= 1'b0;
			irq <= (data_ready && ctl_word[sdl_pkg::CTL_IRQ_RDY]) ||
				(full_flag && ctl_word[sdl_pkg::CTL_LOOP] &&
				ctl_word[sdl_pkg::CTL_IRQ_RDY]) ||
				(wake_tick && wake_irq_en);
			case (state)
				sdl_pkg::SDL_BOOT: begin
					// inhibit skips the power-up copy only, never an update
					if (boot_req) begin
						if (boot_done) begin
							boot_req <= 1'b0;
							state    <= sdl_pkg::SDL_IDLE;
						end
					end else if (boot_pend && !(boot_pwr && boot_inhibit)) begin
						boot_req <= 1'b1;
					end else begin
						state <= sdl_pkg::SDL_IDLE;
					end
				end
				sdl_pkg::SDL_IDLE: begin
					standby <= 1'b1;
					if (boot_pend) begin
						state <= sdl_pkg::SDL_BOOT;
					end else if (log_arm && !ctl_word[sdl_pkg::CTL_RUN]) begin
						standby  <= 1'b0;
						sleeping <= 1'b1;
						state    <= sdl_pkg::SDL_SLEEP;
					end
				end
				sdl_pkg::SDL_SLEEP: begin
					if (boot_pend) begin
						sleeping <= 1'b0;
						state    <= sdl_pkg::SDL_BOOT;
					end else if (!log_arm || ctl_word[sdl_pkg::CTL_RUN] ||
						host_wake) begin
						sleeping <= 1'b0;
						state    <= sdl_pkg::SDL_IDLE;
					end else if (wake_tick) begin
						sleeping   <= 1'b0;
						data_ready <= 1'b0;
						pending    <= {ctl_word[sdl_pkg::CTL_TIME],
							ctl_word[sdl_pkg::CTL_S2],
							ctl_word[sdl_pkg::CTL_S1],
							ctl_word[sdl_pkg::CTL_S0]};
						state      <= sdl_pkg::SDL_PICK;
					end
				end
				sdl_pkg::SDL_PICK: begin
					// next sensor in tag order, stamp first
					if (pending[3]) begin
						if (f_in_ready) begin
							pending[3] <= 1'b0;
						end
					// room first: the done pulse of a sensor is never lost
					end else if (!f_in_ready) begin
						state <= sdl_pkg::SDL_PICK;
					end else if (pending[0]) begin
						cur <= sdl_pkg::TAG_S0;
						pending[0] <= 1'b0;
						state <= sdl_pkg::SDL_CFG;
					end else if (pending[1]) begin
						cur <= sdl_pkg::TAG_S1;
						pending[1] <= 1'b0;
						state <= sdl_pkg::SDL_CFG;
					end else if (pending[2]) begin
						cur <= sdl_pkg::TAG_S2;
						pending[2] <= 1'b0;
						state <= sdl_pkg::SDL_CFG;
					end else begin
						state <= sdl_pkg::SDL_WAIT;
					end
				end
				sdl_pkg::SDL_CFG: begin
					sens_cfg_req <= !sens_cfg_done;
					sens_sel     <= cur;
					if (sens_cfg_done && sens_cfg_req) begin
						acq_start <= 1'b1;
						state     <= sdl_pkg::SDL_ACQ;
					end
				end
				sdl_pkg::SDL_ACQ: begin
					// fifo back-pressure stalls capture
					if (acq_done && (f_in_ready || !keep)) begin
						state <= sdl_pkg::SDL_PICK;
					end
				end
				sdl_pkg::SDL_WAIT: begin
					if (!f_out_valid && !ee_wr_req) begin
						state <= sdl_pkg::SDL_DONE;
					end
				end
				default: begin
					data_ready <= 1'b1;
					sleeping   <= !sleep_mode_sel;
					standby    <= sleep_mode_sel;
					state      <= sleep_mode_sel ? sdl_pkg::SDL_IDLE :
						sdl_pkg::SDL_SLEEP;
				end
			endcase
		end
	end
endmodule

// ===== tb/sdl_assertions.sv
// Purpose: port-level checks of the logging sequencer
// Assumes: single clk_sys domain, rst_b synchronous active low
// Notes:   bound to sdl_top below
module sdl_assertions (
	input wire logic                 clk_sys,
	input wire logic                 rst_b,
	input wire logic                 boot_inhibit,
	input wire logic                 boot_req,
	input wire logic [15:0]          ctl_word,
	input wire logic                 spi_busy,
	input wire logic                 rfid_busy,
	input wire logic [7:0]           spi_cmd_write,
	input wire logic                 sens_cfg_req,
	input wire logic                 sens_cfg_done,
	input wire logic                 acq_start,
	input wire logic                 ee_wr_req,
	input wire logic [7:0]           ee_cmd,
	input wire sdl_pkg::sdl_ee_req_t ee_req,
	input wire logic                 ee_wr_ack,
	input wire logic [15:0]          words_copied,
	input wire logic                 data_ready,
	input wire logic                 irq,
	input wire logic                 sleeping,
	input wire logic                 standby
);
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_b);
	sequence ee_ack_s;
		ee_wr_req && ee_wr_ack;
	endsequence
	sequence cfg_ack_s;
		sens_cfg_req && sens_cfg_done;
	endsequence
	// a write may not start while host traffic or hold must stall it
	sequence stall_s;
		!ee_wr_req && (spi_busy || rfid_busy || ctl_word[sdl_pkg::CTL_HOLD]);
	endsequence
	boot_start_a: assert property ($rose(rst_b) && !boot_inhibit |-> ##[0:2] boot_req)
		else $error("boot copy not requested");
	cfg_then_acq_a: assert property (cfg_ack_s |-> ##[1:2] acq_start)
		else $error("acquisition did not follow configuration");
	acq_pulse_a: assert property (acq_start |-> !sens_cfg_req ##1 !acq_start)
		else $error("bad acquisition start");
	write_hold_a: assert property (ee_wr_req && !ee_wr_ack |=> ee_wr_req && $stable(ee_req))
		else $error("write request dropped or changed");
	count_step_a: assert property (ee_ack_s |=> words_copied == $past(words_copied) + 16'h1)
		else $error("copied count not advanced");
	stall_yield_a: assert property (stall_s |=> !ee_wr_req)
		else $error("write started while stalled");
	ready_irq_a: assert property (data_ready && ctl_word[sdl_pkg::CTL_IRQ_RDY] |-> ##[0:1] irq)
		else $error("data ready without irq");
	mode_excl_a: assert property (!(sleeping && standby))
		else $error("sleep and standby together");
	cmd_copy_a: assert property (ee_wr_req |-> ee_cmd == spi_cmd_write)
		else $error("wrong memory command");
endmodule
bind sdl_top sdl_assertions chk_u (.*);

// ===== tb/sdl_partner.sv
// Purpose: boot copier, sensor and eeprom stand-ins for the sequencer
// Assumes: lat sets answer delay in cycles, 0 is prompt
// Notes:   acq_code shows an inverted pattern outside its done pulse
module sdl_resp (
	input wire logic       clk_sys,
	input wire logic       rst_b,
	input wire logic [3:0] lat,
	input wire logic       req,
	output logic           done
);
	logic [3:0] cnt;
	always_ff @(posedge clk_sys) begin
		if (!rst_b || !req || done) begin
			cnt  <= 4'h0;
			done <= 1'b0;
		end else begin
			cnt  <= cnt + 4'h1;
			done <= (cnt >= lat);
		end
	end
endmodule
module sdl_partner (
	input wire logic        clk_sys,
	input wire logic        rst_b,
	input wire logic [3:0]  lat,
	input wire logic [13:0] code_base,
	input wire logic        boot_req,
	output logic            boot_done,
	input wire logic        sens_cfg_req,
	output logic            sens_cfg_done,
	input wire logic [1:0]  sens_sel,
	input wire logic        acq_start,
	output logic            acq_done,
	output logic [13:0]     acq_code,
	input wire logic        ee_wr_req,
	output logic            ee_wr_ack
);
	logic        acq_pend;
	logic [13:0] code_now;
	always_ff @(posedge clk_sys) begin
		acq_pend <= rst_b && ((acq_pend && !acq_done) || acq_start);
	end
	assign code_now = code_base + 14'(sens_sel);
	// never hold the last code: sampling outside done must fail
	assign acq_code = acq_done ? code_now : ~code_now;
	sdl_resp boot_u (.clk_sys(clk_sys), .rst_b(rst_b), .lat(lat),
		.req(boot_req), .done(boot_done));
	sdl_resp cfg_u (.clk_sys(clk_sys), .rst_b(rst_b), .lat(lat),
		.req(sens_cfg_req), .done(sens_cfg_done));
	sdl_resp acq_u (.clk_sys(clk_sys), .rst_b(rst_b), .lat(lat),
		.req(acq_pend), .done(acq_done));
	sdl_resp ee_u (.clk_sys(clk_sys), .rst_b(rst_b), .lat(lat),
		.req(ee_wr_req), .done(ee_wr_ack));
endmodule

// ===== tb/tb_sdl_top.sv
// Purpose: scenario bench for the logging sequencer
// Assumes: short slave-select wake count in simulation
// Notes:   written words are captured at each acknowledge
module tb_sdl_top;
	timeunit 1ns;
	timeprecision 1ps;
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin error_cnt++; \
	$display("[FAIL] %0t got %h exp %h", $time, a, b); end end
	logic clk_sys = 1'b0, rst_b = 1'b0, boot_inhibit = 1'b1;
	logic update_spi = 1'b0, update_rfid = 1'b0, log_arm = 1'b0;
	logic sleep_mode_sel = 1'b0, wake_irq_en = 1'b0, ss_b = 1'b1;
	logic rf_field = 1'b0, spi_busy = 1'b0, rfid_busy = 1'b0;
	logic [15:0] ctl_word = 16'h0001, dst_addr = 16'h0040;
	logic [15:0] data_len = 16'h0008, wake_period = 16'h0028;
	logic [7:0]  spi_cmd_write = 8'h02, spi_resp_delay = 8'h02;
	logic [2:0]  cond_s0 = 3'h0, cond_s1 = 3'h0, cond_s2 = 3'h0;
	logic [13:0] thr_low = 14'h0101, thr_high = 14'h0101;
	logic [13:0] code_base = 14'h0100, acq_code;
	logic [3:0]  lat = 4'h2;
	logic boot_req, boot_done, sens_cfg_req, sens_cfg_done, acq_start;
	logic acq_done, ee_wr_req, ee_wr_ack, data_ready, full_flag, irq;
	logic sleeping, standby, saw_irq, saw_sleep, saw_stby;
	logic [1:0]  sens_sel;
	logic [7:0]  ee_cmd;
	logic [15:0] words_copied, aq[$], dq[$];
	sdl_pkg::sdl_ee_req_t ee_req;
	int error_cnt = 0, compares = 0;
	sdl_top #(.WAKE_SS_CYCLES(20), .DEPTH(8)) dut_u (.*);
	sdl_partner partner_u (.*);
	always #5 clk_sys = ~clk_sys;
	always @(posedge clk_sys) begin
		if (rst_b && ee_wr_req && ee_wr_ack) begin
			aq.push_back(ee_req.addr);
			dq.push_back(ee_req.data);
		end
		saw_irq = saw_irq | irq;
		saw_sleep = saw_sleep | sleeping;
		saw_stby = saw_stby | standby;
	end
	task automatic end_of_test();
		if (error_cnt == 0 && compares > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	task automatic do_reset(input logic inh);
		@(posedge clk_sys);
		rst_b <= 1'b0;
		boot_inhibit <= inh;
		log_arm <= 1'b0;
		repeat (6) @(posedge clk_sys);
		rst_b <= 1'b1;
		aq.delete();
		dq.delete();
		{saw_irq, saw_sleep, saw_stby} = 3'h0;
	endtask
	task automatic wait_n(input int n);
		for (int i = 0; i < 20000 && aq.size() < n; i++) @(posedge clk_sys);
		if (aq.size() < n) begin
			error_cnt++;
			$display("[FAIL] %0t timeout", $time);
			end_of_test();
		end else begin
			repeat (2) @(posedge clk_sys);
		end
	endtask
	task automatic boot_cycle();
		int i;
		for (i = 0; i < 10 && boot_req !== 1'b1; i++) @(posedge clk_sys);
		`CHK(boot_req, 1'b1)
		for (i = 0; i < 30 && boot_req !== 1'b0; i++) @(posedge clk_sys);
		`CHK(boot_req, 1'b0)
	endtask
	task automatic arm(input logic [15:0] ctl, input logic [15:0] len);
		@(posedge clk_sys);
		ctl_word <= ctl;
		@(posedge clk_sys);
		data_len <= len;
		@(posedge clk_sys);
		wake_period <= 16'h0028;
		@(posedge clk_sys);
		log_arm <= 1'b1;
	endtask
	task automatic t_boot();
		do_reset(1'b0);
		boot_cycle();
		do_reset(1'b1);
		repeat (8) @(posedge clk_sys);
		`CHK(boot_req, 1'b0)
		update_rfid <= 1'b1;
		@(posedge clk_sys);
		update_rfid <= 1'b0;
		boot_cycle();
		update_spi <= 1'b1;
		@(posedge clk_sys);
		update_spi <= 1'b0;
		boot_cycle();
	endtask
	task automatic t_log();
		logic [1:0] tg;
		do_reset(1'b1);
		arm(16'hf004, 16'h0008);
		wait_n(8);
		for (int i = 0; i < 8; i++) begin
			tg = (i % 4 == 0) ? sdl_pkg::TAG_TIME : 2'(i % 4 - 1);
			`CHK(aq[i], 16'h0040 + 16'(i))
			`CHK(dq[i][15:14], tg)
			if (i % 4 != 0) `CHK(dq[i][13:0], 14'h0100 + 14'(tg))
		end
		`CHK(dq[4][13:0], dq[0][13:0] + 14'h1)
		`CHK(words_copied, 16'h0008)
		repeat (200) @(posedge clk_sys);
		`CHK(aq.size(), 8)
		`CHK(full_flag, 1'b1)
		`CHK(saw_sleep, 1'b1)
	endtask
	task automatic t_cond();
		do_reset(1'b1);
		{cond_s0, cond_s1, cond_s2} <= {sdl_pkg::COND_ABOVE,
			sdl_pkg::COND_BELOW, sdl_pkg::COND_OUTSIDE};
		spi_busy <= 1'b1;
		lat <= 4'h6;
		arm(16'hf000, 16'h0010);
		repeat (300) @(posedge clk_sys);
		`CHK(aq.size(), 0)
		{spi_busy, rfid_busy} <= 2'h1;
		repeat (100) @(posedge clk_sys);
		`CHK(aq.size(), 0)
		rfid_busy <= 1'b0;
		ctl_word <= 16'hf002;
		repeat (100) @(posedge clk_sys);
		`CHK(aq.size(), 0)
		ctl_word <= 16'hf000;
		wait_n(4);
		for (int i = 0; i < 4; i++)
			`CHK(dq[i][15:14], i[0] ? sdl_pkg::TAG_S2 : sdl_pkg::TAG_TIME)
		{cond_s0, cond_s1, cond_s2} <= 9'h0;
		lat <= 4'h2;
	endtask
	task automatic t_loop();
		int n;
		do_reset(1'b1);
		{wake_irq_en, sleep_mode_sel} <= 2'h3;
		arm(16'hb00c, 16'h0004);
		wait_n(6);
		`CHK(aq[4], 16'h0040)
		`CHK(aq[5], 16'h0041)
		`CHK(saw_irq, 1'b1)
		`CHK(full_flag, 1'b1)
		`CHK(saw_stby, 1'b1)
		// host stops logging with the run bit
		ctl_word <= 16'hb00d;
		repeat (100) @(posedge clk_sys);
		n = aq.size();
		repeat (300) @(posedge clk_sys);
		`CHK(aq.size(), n)
	endtask
	// long period so only the pins can end the sleep
	task automatic t_wake();
		int i;
		do_reset(1'b1);
		arm(16'h8000, 16'h0008);
		wake_period <= 16'h0fff;
		repeat (10) @(posedge clk_sys);
		`CHK(sleeping, 1'b1)
		rf_field <= 1'b1;
		for (i = 0; i < 8 && sleeping !== 1'b0; i++) @(posedge clk_sys);
		`CHK(sleeping, 1'b0)
		rf_field <= 1'b0;
		repeat (10) @(posedge clk_sys);
		ss_b <= 1'b0;
		repeat (10) @(posedge clk_sys);
		`CHK(sleeping, 1'b1)
		for (i = 0; i < 30 && sleeping !== 1'b0; i++) @(posedge clk_sys);
		`CHK(sleeping, 1'b0)
		ss_b <= 1'b1;
	endtask
	initial begin
		t_boot();
		t_log();
		t_cond();
		t_loop();
		t_wake();
		end_of_test();
	end
endmodule
